// ==== bench/xirqp_ctrl_props.sv ====
`timescale 1ns/1ps

module xirqp_ctrl_props (
    input wire logic        clk_sys_i,
    input wire logic        arst_n_i,
    input wire logic [3:0]  reg_addr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic        pull_enable_o,
    input wire logic        pull_up_o,
    input wire logic        pin_level_o,
    input wire logic        wake_o,
    input wire logic        reset_src_i,
    input wire logic        swi_i,
    input wire logic        cpu_req_o,
    input wire logic [4:0]  vec_num_o,
    input wire logic [15:0] vec_addr_o
);
    logic [7:0] ctrl_q;

    // shadow of the control register; ack bit is write-only
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_q <= 8'h00;
        end else if (reg_wr_i && reg_addr_i == 4'h0) begin
            ctrl_q <= reg_wdata_i & 8'h73;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    AST_PULL_ON: assert property ($stable(ctrl_q) |->
        pull_enable_o == (ctrl_q[4] & ~ctrl_q[6])) else $error("pull on");
    AST_PULL_DIR: assert property ($stable(ctrl_q) |->
        pull_up_o == ~ctrl_q[5]) else $error("pull direction");
    AST_PIN_OFF: assert property (!ctrl_q[4] && $stable(ctrl_q) |->
        !pin_level_o && !wake_o) else $error("pin active while off");
    AST_CTRL_RD: assert property ($past(reg_rd_i && reg_addr_i == 4'h0)
        |-> reg_rdata_o == $past(ctrl_q)) else $error("control readback");
    AST_LEVEL_RD: assert property ($past(reg_rd_i && reg_addr_i == 4'h1)
        |-> reg_rdata_o[1] == pin_level_o) else $error("level read");
    AST_VEC_ADDR: assert property (vec_addr_o ==
        16'hFFFE - {10'h000, vec_num_o, 1'b0}) else $error("vector address");
    AST_REQ_NONE: assert property (cpu_req_o ==
        (vec_num_o != 5'h1F)) else $error("request without winner");
    AST_RESET_WIN: assert property (reset_src_i [*2] |=>
        vec_num_o == 5'h00) else $error("reset vector lost");
    AST_SWI_WIN: assert property ((swi_i && !reset_src_i) [*2] |=>
        vec_num_o == 5'h01) else $error("vector one lost");

    // main scenarios seen
    cover property (cpu_req_o && vec_num_o == 5'h02);
    cover property (vec_num_o == 5'h13);
    cover property ($rose(pull_enable_o));
endmodule : xirqp_ctrl_props

// ==== bench/xirqp_ctrl_tb.sv ====
`timescale 1ns/1ps

module xirqp_ctrl_tb;
    logic        clk_sys_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic [3:0]  reg_addr_i = 4'h0;
    logic [7:0]  reg_wdata_i = 8'h00;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic        reset_src_i = 1'b0;
    logic        swi_i = 1'b0;
    logic [2:0]  tk_flag_i = 3'h0;
    logic [2:0]  tk_en_i = 3'h0;
    logic [31:0] src_flag_i = 32'h0000_0000;
    logic [31:0] src_en_i = 32'h0000_0000;
    logic        drv_en = 1'b1;
    logic        drv_val = 1'b1;
    logic [7:0]  reg_rdata_o, d;
    logic [4:0]  vec_num_o;
    logic [15:0] vec_addr_o;
    logic        req_pin_i, pull_enable_o, pull_up_o, pin_level_o;
    logic        wake_o, cpu_req_o, irq_o;
    int          miscompares = 0;
    int          checks_done = 0;
    int          cycles = 0;

    // 100 MHz system clock
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    xirqp_pin_model PIN (.clk_sys_i(clk_sys_i), .drv_en_i(drv_en),
        .drv_val_i(drv_val), .pull_enable_i(pull_enable_o),
        .pull_up_i(pull_up_o), .pin_o(req_pin_i));

    xirqp_ctrl DUT (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .req_pin_i(req_pin_i), .pull_enable_o(pull_enable_o),
        .pull_up_o(pull_up_o), .pin_level_o(pin_level_o), .wake_o(wake_o),
        .reset_src_i(reset_src_i), .swi_i(swi_i), .tk_flag_i(tk_flag_i),
        .tk_en_i(tk_en_i), .src_flag_i(src_flag_i), .src_en_i(src_en_i),
        .vec_ack_i(1'b0), .cpu_req_o(cpu_req_o), .vec_num_o(vec_num_o),
        .vec_addr_o(vec_addr_o), .irq_o(irq_o));

    task wrap_up;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    // a hung handshake ends the run as a failure
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            wrap_up();
        end
    end

    task chk(input string n, input logic [15:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk

    task wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 v = reg_rdata_o;
    endtask : rd

    // pin moves pass a synchroniser, so allow settling time
    task pin(input logic v);
        drv_val <= v;
        repeat (10) @(posedge clk_sys_i);
    endtask : pin

    task prio(input logic [31:0] f, e, input logic [2:0] tf, te,
              input logic [4:0] n);
        src_flag_i <= f;
        src_en_i <= e;
        tk_flag_i <= tf;
        tk_en_i <= te;
        repeat (4) @(posedge clk_sys_i);
        #1 chk("vec_num", vec_num_o, n);
        chk("vec_addr", vec_addr_o, 16'hFFFE - {n, 1'b0});
        chk("cpu_req", cpu_req_o, n != 5'h1F);
        // hand back on an edge so the caller drives inputs there
        @(posedge clk_sys_i);
    endtask : prio

    // main sequence
    initial begin
        repeat (8) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        #1 chk("pull_up", pull_up_o, 1'b1);
        wr(4'h0, 8'h47);
        wr(4'hF, 8'hFF);
        rd(4'h0, d);
        chk("ctrl", d, 8'h43);
        rd(4'hF, d);
        chk("unmapped", d, 8'h00);
        wr(4'h0, 8'h00);
        prio(32'h0000_0120, 32'h0000_0120, 3'h0, 3'h0, 5'h05);
        prio(32'h0000_0120, 32'h0000_0100, 3'h0, 3'h0, 5'h08);
        prio(32'h0000_0000, 32'h0000_0000, 3'h4, 3'h3, 5'h1F);
        prio(32'h0000_0000, 32'h0000_0000, 3'h4, 3'h4, 5'h13);
        reset_src_i <= 1'b1;
        prio(32'h0000_0120, 32'h0000_0120, 3'h1, 3'h1, 5'h00);
        reset_src_i <= 1'b0;
        swi_i <= 1'b1;
        prio(32'h0000_0120, 32'h0000_0120, 3'h0, 3'h0, 5'h01);
        swi_i <= 1'b0;
        prio(32'hFF80_0000, 32'hFFFF_FFFF, 3'h0, 3'h0, 5'h1F);
        wr(4'h0, 8'h12);
        pin(1'b0);
        rd(4'h1, d);
        chk("flag", d[0], 1'b1);
        chk("level", d[1], 1'b0);
        chk("pin_vec", vec_num_o, 5'h02);
        chk("irq_masked", irq_o, 1'b0);
        chk("wake", wake_o, 1'b1);
        chk("pin_level", pin_level_o, 1'b0);
        rd(4'h4, d);
        chk("vector", d, 8'h82);
        wr(4'h6, 8'h01);
        repeat (2) @(posedge clk_sys_i);
        #1 chk("irq_on", irq_o, 1'b1);
        rd(4'h5, d);
        chk("irq_stat", d, 8'h03);
        rd(4'h6, d);
        chk("irq_mask", d, 8'h01);
        wr(4'h5, 8'h03);
        repeat (2) @(posedge clk_sys_i);
        #1 chk("irq_off", irq_o, 1'b0);
        wr(4'h0, 8'h16);
        rd(4'h1, d);
        chk("edge_ack", d[0], 1'b0);
        wr(4'h0, 8'h10);
        pin(1'b1);
        pin(1'b0);
        rd(4'h1, d);
        chk("poll_flag", d[0], 1'b1);
        chk("no_req", cpu_req_o, 1'b0);
        wr(4'h0, 8'h14);
        pin(1'b1);
        wr(4'h0, 8'h13);
        pin(1'b0);
        wr(4'h0, 8'h17);
        rd(4'h1, d);
        chk("level_hold", d[0], 1'b1);
        pin(1'b1);
        wr(4'h0, 8'h17);
        rd(4'h1, d);
        chk("level_ack", d[0], 1'b0);
        wr(4'h0, 8'h30);
        repeat (2) @(posedge clk_sys_i);
        #1 chk("pull_down", pull_up_o, 1'b0);
        chk("pull_en", pull_enable_o, 1'b1);
        drv_en <= 1'b0;
        pin(1'b0);
        rd(4'h1, d);
        chk("pulled", d[1], 1'b0);
        drv_en <= 1'b1;
        pin(1'b1);
        rd(4'h1, d);
        chk("rise_flag", d[0], 1'b1);
        wr(4'h0, 8'h70);
        repeat (2) @(posedge clk_sys_i);
        #1 chk("pull_off", pull_enable_o, 1'b0);
        wr(4'h0, 8'h74);
        wr(4'h0, 8'h00);
        pin(1'b0);
        pin(1'b1);
        rd(4'h1, d);
        chk("disabled", d, 8'h00);
        wrap_up();
    end
endmodule : xirqp_ctrl_tb

bind xirqp_ctrl xirqp_ctrl_props u_props (.clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .pull_enable_o(pull_enable_o), .pull_up_o(pull_up_o),
    .pin_level_o(pin_level_o), .wake_o(wake_o), .reset_src_i(reset_src_i),
    .swi_i(swi_i), .cpu_req_o(cpu_req_o), .vec_num_o(vec_num_o),
    .vec_addr_o(vec_addr_o));

// ==== bench/xirqp_pin_model.sv ====
`timescale 1ns/1ps

// far-side request source: drives the pin, or leaves it to the pull device
module xirqp_pin_model (
    input  wire logic clk_sys_i,
    input  wire logic drv_en_i,
    input  wire logic drv_val_i,
    input  wire logic pull_enable_i,
    input  wire logic pull_up_i,
    output logic      pin_o
);
    logic last_reg;

    // remember the driven level; a floating pin shows its inverse
    always @(posedge clk_sys_i) begin
        if (drv_en_i) begin
            last_reg <= pin_o;
        end
    end

    // a released pin with no pull must not look like the old level
    assign pin_o = drv_en_i ? drv_val_i :
                   pull_enable_i ? pull_up_i : ~last_reg;
endmodule : xirqp_pin_model

// ==== core/xirqp_ctrl.sv ====
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "xirqp_defines.svh"

// Notes on behaviour
// (R01) pin requests only while function enabled; here pe_reg gates new edges, not an already set flag
// (R02) software picks polarity and edge/level mode
// (R03) event sets flag; enable gates request
// (R04) internal pull on when enabled, not disabled
// (R05) pull disable bit switches pull off
// (R06) pin level readable for branch instructions
// (R07) edge-level mode: assert edge sets flag
// (R08) flag held, clear ignored while asserted
// (R09) vector word: high byte first, low next
// (R10) source flag forwards only with enable
// (R11) core stacks registers then fetches vector
// (R12) lowest vector number wins priority
// (R13) vectors 31..23 have no source
// (R14) vector 19 from gated timekeeper flags
// (R15) polarity 0 falling/low, 1 rising/high
// (R16) async wake path while clocks stopped; here wake_o is a register clocked by clk_sys_i
// (R17) pin is vector 2, reset vector 0
// (R18) edge-only: edge sets, acknowledge clears
// (R19) pin request is flag and enable
module xirqp_ctrl #(
    parameter int NUM_VEC = 32
) (
    input  wire logic        clk_sys_i,
    input  wire logic        arst_n_i,
    // register port
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    // external request pin
    input  wire logic        req_pin_i,
    output logic             pull_enable_o,
    output logic             pull_up_o,
    output logic             pin_level_o,
    output logic             wake_o,
    // sources from the rest of the chip
    input  wire logic        reset_src_i,
    input  wire logic        swi_i,
    input  wire logic [2:0]  tk_flag_i,
    input  wire logic [2:0]  tk_en_i,
    input  wire logic [31:0] src_flag_i,
    input  wire logic [31:0] src_en_i,
    // processor side
    input  wire logic        vec_ack_i,
    output logic             cpu_req_o,
    output logic      [4:0]  vec_num_o,
    output logic      [15:0] vec_addr_o,
    output logic             irq_o
);

    // elaboration check: the priority decode is sized for 32 vectors
    if (NUM_VEC != 32) begin : g_num_vec_check
        $error("xirqp_ctrl serves exactly 32 vectors");
    end

    logic                        pin_lvl;
    logic                        pin_lvl_q_reg;
    logic                        pe_reg;
    logic                        pdd_reg;
    xirqp_pkg::xirqp_mode_type   mode_reg;
    logic                        edg_reg;
    logic                        ie_reg;
    logic                        flag_reg;
    logic                        asserted;
    logic                        edge_hit;
    logic                        ack_wr;
    logic                        ctrl_wr;
    logic [31:0]                 pending;
    logic [4:0]                  winner;
    logic                        any_pend;
    logic [1:0]                  ev_stat_reg;
    logic [1:0]                  ev_mask_reg;
    logic                        any_pend_q_reg;

    // lowest index set bit: priority decode reused for vector number, address and readback
    function automatic logic [4:0] first_set(input logic [31:0] v);
        logic [4:0] r;
        r = `XIRQP_VEC_NONE;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction : first_set

    xirqp_pin_sync u_sync (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .pin_i     (req_pin_i),
        .level_o   (pin_lvl)
    );

    // asserted level follows polarity: 0 low active, 1 high active
    assign asserted = edg_reg ? pin_lvl : ~pin_lvl; // [R02] [R15]
    assign edge_hit = pe_reg & asserted &
                      (edg_reg ? ~pin_lvl_q_reg : pin_lvl_q_reg); // [R01] [R07]
    assign ctrl_wr  = reg_wr_i && (reg_addr_i == `XIRQP_ADDR_CTRL);
    assign ack_wr   = ctrl_wr && reg_wdata_i[`XIRQP_CTRL_ACK];

    // previous synchronised level, for edge detection
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_lvl_q_reg <= 1'b1;
        end else begin
            pin_lvl_q_reg <= pin_lvl;
        end
    end

    // control bits written by software
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pe_reg   <= 1'b0;
            pdd_reg  <= 1'b0;
            edg_reg  <= 1'b0;
            ie_reg   <= 1'b0;
            mode_reg <= xirqp_pkg::XIRQP_EDGE_ONLY;
        end else if (ctrl_wr) begin
            pe_reg   <= reg_wdata_i[`XIRQP_CTRL_PE];           // [R01]
            pdd_reg  <= reg_wdata_i[`XIRQP_CTRL_PDD];          // [R05]
            edg_reg  <= reg_wdata_i[`XIRQP_CTRL_EDG];          // [R02]
            ie_reg   <= reg_wdata_i[`XIRQP_CTRL_IE];           // [R03]
            mode_reg <= reg_wdata_i[`XIRQP_CTRL_MODE] ?
                        xirqp_pkg::XIRQP_EDGE_LEVEL :
                        xirqp_pkg::XIRQP_EDGE_ONLY;            // [R02]
        end
    end

    // event flag: set wins over acknowledge; level mode holds it set
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flag_reg <= 1'b0;
        end else if (edge_hit) begin
            flag_reg <= 1'b1;                                  // [R03] [R07]
        end else if (mode_reg == xirqp_pkg::XIRQP_EDGE_LEVEL &&
                     pe_reg && asserted && flag_reg) begin
            flag_reg <= 1'b1;                                  // [R08]
        end else if (ack_wr) begin
            flag_reg <= 1'b0;                                  // [R18]
        end
    end

    // pull device and observable pin level
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pull_enable_o <= 1'b0;
            pull_up_o     <= 1'b1;
            pin_level_o   <= 1'b0;
            wake_o        <= 1'b0;
        end else begin
            pull_enable_o <= pe_reg & ~pdd_reg;                // [R04] [R05]
            pull_up_o     <= ~edg_reg;                         // [R15]
            pin_level_o   <= pe_reg & pin_lvl;                 // [R06]
            // synchronous stand-in; true stop-mode wake is outside
            wake_o        <= pe_reg & asserted;                // [R16]
        end
    end

    // pending sources; free vectors stay out, the software slot follows swi_i
    always_comb begin
        pending = src_flag_i & src_en_i;                       // [R10]
        pending[`XIRQP_VEC_RESET]    = reset_src_i;            // [R17]
        pending[`XIRQP_VEC_SWI]      = swi_i;
        pending[`XIRQP_VEC_PIN]      = flag_reg & ie_reg;      // [R19] [R03]
        pending[`XIRQP_VEC_TIMEKEEP] = |(tk_flag_i & tk_en_i); // [R14]
        for (int i = `XIRQP_VEC_FIRST_FREE; i < 32; i++) begin
            pending[i] = 1'b0;                                 // [R13]
        end
    end

    assign winner   = first_set(pending);                      // [R12]
    assign any_pend = |pending;

    // request and vector to the core; core does the stacking itself
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cpu_req_o  <= 1'b0;
            vec_num_o  <= `XIRQP_VEC_NONE;
            // address kept consistent with the idle vector number
            vec_addr_o <= `XIRQP_VEC_TOP -
                          16'({`XIRQP_VEC_NONE, 1'b0});
        end else begin
            cpu_req_o  <= any_pend;                            // [R10] [R11]
            vec_num_o  <= winner;                              // [R12]
            // high byte at the even address, low byte at +1
            vec_addr_o <= `XIRQP_VEC_TOP -
                          16'({winner, 1'b0});                 // [R09]
        end
    end

    // controller interrupt status: sticky, write one to clear, set wins
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ev_stat_reg    <= 2'h0;
            any_pend_q_reg <= 1'b0;
        end else begin
            any_pend_q_reg <= any_pend;
            for (int b = 0; b < 2; b++) begin
                if (reg_wr_i && reg_addr_i == `XIRQP_ADDR_IRQ_STAT &&
                    reg_wdata_i[b]) begin
                    ev_stat_reg[b] <= 1'b0;
                end
            end
            if (edge_hit) begin
                ev_stat_reg[`XIRQP_EV_PIN] <= 1'b1;
            end
            if (any_pend && !any_pend_q_reg) begin
                ev_stat_reg[`XIRQP_EV_ANY] <= 1'b1;
            end
        end
    end

    // mask register
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ev_mask_reg <= 2'h0;
        end else if (reg_wr_i && reg_addr_i == `XIRQP_ADDR_IRQ_MASK) begin
            ev_mask_reg <= reg_wdata_i[1:0];
        end
    end

    // level interrupt output
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(ev_stat_reg & ev_mask_reg);
        end
    end

    // read data one cycle after the strobe; zero otherwise
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (!reg_rd_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_addr_i == `XIRQP_ADDR_CTRL) begin
            reg_rdata_o <= {1'b0, pdd_reg, edg_reg, pe_reg, 2'b00,
                            ie_reg, mode_reg == xirqp_pkg::XIRQP_EDGE_LEVEL};
        end else if (reg_addr_i == `XIRQP_ADDR_STATUS) begin
            reg_rdata_o <= {6'h00, pe_reg & pin_lvl, flag_reg};  // [R06]
        end else if (reg_addr_i == `XIRQP_ADDR_VECTOR) begin
            reg_rdata_o <= {any_pend, 2'b00, winner};
        end else if (reg_addr_i == `XIRQP_ADDR_IRQ_STAT) begin
            reg_rdata_o <= {6'h00, ev_stat_reg};
        end else if (reg_addr_i == `XIRQP_ADDR_IRQ_MASK) begin
            reg_rdata_o <= {6'h00, ev_mask_reg};
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

endmodule : xirqp_ctrl

// ==== core/xirqp_pin_sync.sv ====
`timescale 1ns/1ps
`include "xirqp_defines.svh"

// three-stage synchroniser; the level only moves when stages two and
// three agree, so a single glitch on the pin never reaches the detector
module xirqp_pin_sync (
    input  wire logic clk_sys_i,
    input  wire logic arst_n_i,
    input  wire logic pin_i,
    output logic      level_o
);

    logic meta_reg;
    logic s2_reg;
    logic s3_reg;

    // chain of flops; meta_reg feeds s2_reg only
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_reg <= 1'b1;
            s2_reg   <= 1'b1;
            s3_reg   <= 1'b1;
        end else begin
            meta_reg <= pin_i;
            s2_reg   <= meta_reg;
            s3_reg   <= s2_reg;
        end
    end

    // filtered level, idle high like a pulled-up request line
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            level_o <= 1'b1;
        end else if (s2_reg == s3_reg) begin
            level_o <= s3_reg;
        end
    end

endmodule : xirqp_pin_sync

// ==== include/xirqp_defines.svh ====
`ifndef XIRQP_DEFINES_SVH
`define XIRQP_DEFINES_SVH

// register addresses (byte offsets on the plain register port)
`define XIRQP_ADDR_CTRL      4'h0
`define XIRQP_ADDR_STATUS    4'h1
`define XIRQP_ADDR_SRC_FLAG  4'h2
`define XIRQP_ADDR_SRC_EN    4'h3
`define XIRQP_ADDR_VECTOR    4'h4
`define XIRQP_ADDR_IRQ_STAT  4'h5
`define XIRQP_ADDR_IRQ_MASK  4'h6

// control register fields
`define XIRQP_CTRL_MODE      0
`define XIRQP_CTRL_IE        1
`define XIRQP_CTRL_ACK       2
`define XIRQP_CTRL_PE        4
`define XIRQP_CTRL_EDG       5
`define XIRQP_CTRL_PDD       6
`define XIRQP_CTRL_RESET     8'h00

// status register fields
`define XIRQP_STAT_FLAG      0
`define XIRQP_STAT_LEVEL     1

// vector numbering and layout
`define XIRQP_VEC_RESET      5'h00
`define XIRQP_VEC_SWI        5'h01
`define XIRQP_VEC_PIN        5'h02
`define XIRQP_VEC_TIMEKEEP   5'h13
`define XIRQP_VEC_FIRST_FREE 5'h17
`define XIRQP_VEC_TOP        16'hFFFE
`define XIRQP_VEC_NONE       5'h1F

// timekeeper request sub-fields
`define XIRQP_TK_QSEC        0
`define XIRQP_TK_SEC         1
`define XIRQP_TK_MATCH       2

// controller interrupt status bits
`define XIRQP_EV_PIN         0
`define XIRQP_EV_ANY         1

`endif

// ==== include/xirqp_pkg.sv ====
package xirqp_pkg;

    // pin detection modes
    typedef enum logic {
        XIRQP_EDGE_ONLY,
        XIRQP_EDGE_LEVEL
    } xirqp_mode_type;

    // vector arbiter states; not used, first_set picks the winner combinationally
    typedef enum logic [1:0] {
        XIRQP_ARB_IDLE,
        XIRQP_ARB_HOLD
    } xirqp_arb_type;

endpackage : xirqp_pkg
